// ==== src/spline_area_consts.svh ====
// constants for the spline download area: offsets, limits, pacing
`ifndef SPLINE_AREA_CONSTS_SVH
`define SPLINE_AREA_CONSTS_SVH

`define AREA_BASE 16'h3000
`define AREA_WORDS 4096
`define AREA_IDX_W 12
`define WORD_W 16

`define AX0_IVL_LAYOUT 16'h3000
`define AX0_IVL_ARRAY 16'h3001
`define AX1_IVL_LAYOUT 16'h3400
`define AX1_IVL_ARRAY 16'h3401
`define AX0_PT_TOTAL 16'h3800
`define AX0_PT_ARRAY 16'h3801
`define AX1_PT_TOTAL 16'h3c00
`define AX1_PT_ARRAY 16'h3c01

`define LAYOUT_STATIC0 16'h0000
`define LAYOUT_STATIC1 16'h0001
`define LAYOUT_DYNAMIC 16'h0002

`define MAX_INTERVALS 10'h3fe
`define MAX_POINTS 10'h3ff

`define FIRST_LOOP_PTS 4'h4
`define LATER_LOOP_PTS 4'h7
`define FAST_BUDGET 4'hf

`define SPLINE_AXES 2
`define FIFO_DEPTH 16

`endif

// ==== src/spline_area_pkg.sv ====
// types for the spline download area
package spline_area_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_LOAD,
		ST_RUN
	} area_state_t;

	typedef logic [15:0] word_t;

endpackage

// ==== src/seg_fifo.sv ====
// parameterised flip-flop fifo for finished segment words
`timescale 1ns/1ps
module seg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==== src/spline_download_area.sv ====
// spline download area: register store, layout check, paced segment build
`timescale 1ns/1ps
`include "spline_area_consts.svh"

module spline_download_area
	import spline_area_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register map access
	input wire logic map_en,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata_q,
	output logic rvalid_q,
	// pacing and mode
	input wire logic loop_tick,
	input wire logic comm_calc,
	input wire logic area_start,
	// per-point command method
	input wire logic [1:0] cmd_point,
	input wire logic [1:0] cmd_end,
	// status
	output logic [1:0] ack_q,
	output logic busy_q,
	output logic layout_err_q,
	output logic dynamic_q,
	// finished segment words
	output logic seg_valid,
	output logic [15:0] seg_data,
	input wire logic seg_ready
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [11:0] area_idx(input logic [15:0] a);
		area_idx = a[11:0];
	endfunction

	function automatic logic hit(input logic [15:0] a);
		hit = (a >= `AREA_BASE) &&
			(a < (`AREA_BASE + 16'(`AREA_WORDS)));
	endfunction

	function automatic logic [9:0] clamp_pts(input word_t w);
		clamp_pts = (w > 16'(`MAX_POINTS)) ? `MAX_POINTS : w[9:0];
	endfunction

	function automatic logic [9:0] take(input logic [9:0] r,
		input logic [3:0] n);
		take = (r > 10'(n)) ? (r - 10'(n)) : 10'h000;
	endfunction

	// ************************************************************
	// register store
	// ************************************************************
	word_t mem_q [`AREA_WORDS];
	wire acc_ok = map_en && hit(addr);
	wire wr_ok = wr_en && acc_ok;
	wire [11:0] acc_idx = area_idx(addr);

	// full-width words, written in any order or block size
	always_ff @(posedge clk) begin
		if (wr_ok) begin
			mem_q[acc_idx] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd_en;
			rdata_q <= (rd_en && acc_ok) ? mem_q[acc_idx] : 16'h0000;
		end
	end

	// ************************************************************
	// area build sequencer
	// ************************************************************
	// static two-axis map; other axis counts not built here
	wire [11:0] ivl_base0 = area_idx(`AX0_IVL_LAYOUT);
	wire [11:0] pt_base0 = area_idx(`AX0_PT_TOTAL);
	wire [11:0] pt_base1 = area_idx(`AX1_PT_TOTAL);
	wire [11:0] ivl_base1 = area_idx(`AX1_IVL_LAYOUT);

	area_state_t state_q;
	logic axis_q;
	logic [9:0] rem_q;
	logic [9:0] pidx_q;
	logic [3:0] budget_q;
	logic [1:0] area_done;
	logic fifo_ready;
	logic push;
	logic [9:0] ivl_total_q;

	wire word_t layout = mem_q[ivl_base0];
	wire layout_bad = layout > `LAYOUT_DYNAMIC;
	wire [11:0] pt_base = axis_q ? pt_base1 : pt_base0;
	wire [11:0] ivl_base = axis_q ? ivl_base1 : ivl_base0;
	wire [11:0] pt_rd = pt_base + 12'h001 + {2'b00, pidx_q};
	wire in_run = (state_q == ST_RUN);
	wire need_pt = in_run && (rem_q != 10'h000);
	wire refill = need_pt && (budget_q == 4'h0) && loop_tick;

	assign push = need_pt && (budget_q != 4'h0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			axis_q <= 1'b0;
			rem_q <= 10'h000;
			pidx_q <= 10'h000;
			budget_q <= 4'h0;
			layout_err_q <= 1'b0;
			dynamic_q <= 1'b0;
			ivl_total_q <= 10'h000;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (area_start) begin
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					// one layout word decides for the whole area
					layout_err_q <= layout_bad;
					dynamic_q <= (layout == `LAYOUT_DYNAMIC);
					axis_q <= 1'b0;
					state_q <= layout_bad ? ST_IDLE : ST_LOAD;
				end
				ST_LOAD: begin
					rem_q <= clamp_pts(mem_q[pt_base]);
					ivl_total_q <= (mem_q[ivl_base] > 16'(`MAX_INTERVALS)) ?
						`MAX_INTERVALS : mem_q[ivl_base][9:0];
					pidx_q <= 10'h000;
					budget_q <= comm_calc ? `FAST_BUDGET : `FIRST_LOOP_PTS;
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (rem_q == 10'h000) begin
						// axes handled one after another
						axis_q <= 1'b1;
						state_q <= axis_q ? ST_IDLE : ST_LOAD;
					end else if (refill) begin
						budget_q <= `LATER_LOOP_PTS;
					end else if (push && fifo_ready) begin
						rem_q <= rem_q - 10'h001;
						pidx_q <= pidx_q + 10'h001;
						if (!comm_calc) begin
							budget_q <= budget_q - 4'h1;
						end
					end
				end
			endcase
		end
	end

	assign area_done[0] = in_run && (rem_q == 10'h000) && !axis_q;
	assign area_done[1] = in_run && (rem_q == 10'h000) && axis_q;

	// ************************************************************
	// per-point command path, both axes in parallel
	// ************************************************************
	logic [9:0] pts_q [2];
	logic [9:0] crem_q [2];
	logic [1:0] cbusy_q;
	logic [1:0] cmd_done;

	// each axis keeps its own countdown so the slowest sets the time
	always_comb begin
		for (int a = 0; a < 2; a++) begin
			cmd_done[a] = (cmd_end[a] && !cbusy_q[a] &&
				take(pts_q[a], `FIRST_LOOP_PTS) == 10'h000) ||
				(cbusy_q[a] && loop_tick &&
				take(crem_q[a], `LATER_LOOP_PTS) == 10'h000);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int a = 0; a < 2; a++) begin
				pts_q[a] <= 10'h000;
				crem_q[a] <= 10'h000;
			end
			cbusy_q <= 2'b00;
		end else begin
			for (int a = 0; a < 2; a++) begin
				if (cmd_end[a] && !cbusy_q[a]) begin
					crem_q[a] <= take(pts_q[a], `FIRST_LOOP_PTS);
					cbusy_q[a] <= !cmd_done[a];
					pts_q[a] <= 10'h000;
				end else if (cbusy_q[a] && loop_tick) begin
					crem_q[a] <= take(crem_q[a], `LATER_LOOP_PTS);
					cbusy_q[a] <= !cmd_done[a];
				end else if (cmd_point[a] && pts_q[a] != `MAX_POINTS) begin
					pts_q[a] <= pts_q[a] + 10'h001;
				end
			end
		end
	end

	// ************************************************************
	// acknowledge and busy
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 2'b00;
			busy_q <= 1'b0;
		end else begin
			ack_q <= ack_q ^ (cmd_done | area_done);
			busy_q <= (state_q != ST_IDLE) || (cbusy_q != 2'b00);
		end
	end

	// ************************************************************
	// segment output buffer
	// ************************************************************
	// a stalled drain freezes the build, never drops a point
	seg_fifo #(
		.WIDTH(`WORD_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_data(mem_q[pt_rd]),
		.in_ready(fifo_ready),
		.out_valid(seg_valid),
		.out_data(seg_data),
		.out_ready(seg_ready)
	);

	// ************************************************************
	// checks
	// ************************************************************
	property p_wr_store;
		@(posedge clk) disable iff (!rst_n)
		wr_ok |=> mem_q[$past(acc_idx)] == $past(wdata);
	endproperty
	a_wr_store: assert property (p_wr_store)
		else $error("area write not stored");

	property p_no_map;
		@(posedge clk) disable iff (!rst_n)
		(rd_en && !map_en) |=> (rvalid_q && rdata_q == 16'h0000);
	endproperty
	a_no_map: assert property (p_no_map)
		else $error("read without register map returned data");

	property p_bad_layout;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_CHECK && layout_bad) |=>
			(layout_err_q && state_q == ST_IDLE);
	endproperty
	a_bad_layout: assert property (p_bad_layout)
		else $error("bad layout not rejected");

	property p_dynamic;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_CHECK && layout == `LAYOUT_DYNAMIC) |=>
			(dynamic_q && state_q == ST_LOAD);
	endproperty
	a_dynamic: assert property (p_dynamic)
		else $error("dynamic layout not taken");

	property p_static;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_CHECK && layout < `LAYOUT_DYNAMIC) |=> !dynamic_q;
	endproperty
	a_static: assert property (p_static)
		else $error("static layout not taken");

	property p_first_budget;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_LOAD) |=>
			(budget_q == ($past(comm_calc) ? `FAST_BUDGET : `FIRST_LOOP_PTS));
	endproperty
	a_first_budget: assert property (p_first_budget)
		else $error("first loop budget wrong");

	property p_refill;
		@(posedge clk) disable iff (!rst_n)
		refill |=> budget_q == `LATER_LOOP_PTS;
	endproperty
	a_refill: assert property (p_refill)
		else $error("later loop budget wrong");

	property p_axis_seq;
		@(posedge clk) disable iff (!rst_n)
		area_done[0] |=> (state_q == ST_LOAD && axis_q) ##1 in_run;
	endproperty
	a_axis_seq: assert property (p_axis_seq)
		else $error("axes not handled in sequence");

	// pushed plus pending never exceeds one clamped table
	property p_pt_limit;
		@(posedge clk) disable iff (!rst_n)
		(({1'b0, rem_q} + {1'b0, pidx_q}) <= 11'(`MAX_POINTS)) &&
			(pts_q[0] <= `MAX_POINTS);
	endproperty
	a_pt_limit: assert property (p_pt_limit)
		else $error("point count over limit");

	property p_ivl_limit;
		@(posedge clk) disable iff (!rst_n)
		ivl_total_q <= `MAX_INTERVALS;
	endproperty
	a_ivl_limit: assert property (p_ivl_limit)
		else $error("interval count over limit");

	property p_ack_toggle;
		@(posedge clk) disable iff (!rst_n)
		cmd_done[0] |=> ack_q[0] != $past(ack_q[0]);
	endproperty
	a_ack_toggle: assert property (p_ack_toggle)
		else $error("acknowledge did not toggle");

	property p_concurrent;
		@(posedge clk) disable iff (!rst_n)
		(cbusy_q == 2'b11 && loop_tick) |=>
			(crem_q[1] == take($past(crem_q[1]), `LATER_LOOP_PTS) &&
			crem_q[0] == take($past(crem_q[0]), `LATER_LOOP_PTS));
	endproperty
	a_concurrent: assert property (p_concurrent)
		else $error("axes not finished concurrently");

	c_area_run: cover property (@(posedge clk) disable iff (!rst_n)
		area_done[1]);
	c_cmd_both: cover property (@(posedge clk) disable iff (!rst_n)
		cbusy_q == 2'b11);
	c_stall: cover property (@(posedge clk) disable iff (!rst_n)
		push && !fifo_ready);
	c_bad: cover property (@(posedge clk) disable iff (!rst_n)
		layout_err_q);
endmodule

// ==== tb/seg_sink.sv ====
// stalling consumer of the finished segment stream
`timescale 1ns/1ps
module seg_sink (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// segment stream
	input wire logic seg_valid,
	input wire logic [15:0] seg_data,
	output logic seg_ready
);
	logic [15:0] words[$];
	logic hs = 1'b0;
	logic [15:0] hd;
	int n = 0;
	initial seg_ready = 1'b0;
	// sampled mid-cycle so the handshake never races the fifo flops
	always @(negedge clk) begin
		hs = seg_valid && seg_ready;
		hd = seg_data;
	end
	// long stalls let the fifo fill up and refuse
	always @(posedge clk) begin
		if (hs && rst_n)
			words.push_back(hd);
		n++;
		#1 seg_ready <= rst_n && (n % 48 < 24);
	end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the spline download area
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic map_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000;
	logic loop_tick = 1'b0, comm_calc = 1'b0, area_start = 1'b0;
	logic [1:0] cmd_point = 2'b00, cmd_end = 2'b00;
	logic [15:0] rdata_q, seg_data;
	logic rvalid_q, busy_q, layout_err_q, dynamic_q, seg_valid, seg_ready;
	logic [1:0] ack_q;
	logic [1:0] exp_ack = 2'b00;
	int mismatches = 0;
	int checked = 0;
	always #2 clk = ~clk;
	spline_download_area spline_download_area_i (.clk(clk), .rst_n(rst_n),
		.map_en(map_en), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
		.loop_tick(loop_tick), .comm_calc(comm_calc),
		.area_start(area_start), .cmd_point(cmd_point), .cmd_end(cmd_end),
		.ack_q(ack_q), .busy_q(busy_q), .layout_err_q(layout_err_q),
		.dynamic_q(dynamic_q), .seg_valid(seg_valid), .seg_data(seg_data),
		.seg_ready(seg_ready));
	seg_sink seg_sink_i (.clk(clk), .rst_n(rst_n), .seg_valid(seg_valid),
		.seg_data(seg_data), .seg_ready(seg_ready));
	// ****************
	// bus and compare
	// ****************
	task step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task chk_ack(input string m);
		chk({14'h0000, ack_q}, {14'h0000, exp_ack}, m);
	endtask
	// strobe stays up across back-to-back writes
	task wr(input logic [15:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		step();
	endtask
	task rd(input logic [15:0] a, input logic [15:0] exp, input string m);
		wr_en = 1'b0;
		addr = a;
		rd_en = 1'b1;
		step();
		rd_en = 1'b0;
		chk({15'h0000, rvalid_q}, 16'h0001, "rvalid");
		chk(rdata_q, exp, m);
		step();
	endtask
	task load(input logic [15:0] lay, input int n0, input int n1);
		wr(16'h3000, lay);
		wr(16'h3800, 16'(n0));
		wr(16'h3c00, 16'(n1));
		for (int i = 0; i < n0; i++)
			wr(16'h3801 + 16'(i), 16'h1000 + 16'(i));
		for (int i = 0; i < n1; i++)
			wr(16'h3c01 + 16'(i), 16'h2000 + 16'(i));
		wr_en = 1'b0;
		seg_sink_i.words.delete();
		area_start = 1'b1;
		step();
		area_start = 1'b0;
	endtask
	task wait_ack(input int b, input bit tick);
		int k;
		k = 0;
		while (ack_q[b] === exp_ack[b] && k < 400) begin
			loop_tick = tick && (k % 8 == 7);
			step();
			k++;
		end
		loop_tick = 1'b0;
		exp_ack[b] = ~exp_ack[b];
		chk_ack("ack toggle");
	endtask
	// ****************
	// scenarios
	// ****************
	task test_regs;
		wr(16'h3000, 16'hffff);
		wr(16'h3fff, 16'ha5c3);
		rd(16'h3000, 16'hffff, "first word");
		rd(16'h3fff, 16'ha5c3, "last word");
		map_en = 1'b0;
		wr(16'h3fff, 16'h1234);
		rd(16'h3fff, 16'h0000, "blocked read");
		map_en = 1'b1;
		rd(16'h3fff, 16'ha5c3, "blocked write");
		rd(16'h2fff, 16'h0000, "unmapped");
		$display("test_regs done");
	endtask
	task test_build;
		logic [15:0] e;
		load(16'h0001, 5, 2);
		step(100);
		chk(16'(seg_sink_i.words.size()), 16'h0004, "first loop");
		chk({15'h0000, busy_q}, 16'h0001, "busy in build");
		chk_ack("held for tick");
		wait_ack(0, 1'b1);
		wait_ack(1, 1'b1);
		step(60);
		chk({15'h0000, busy_q}, 16'h0000, "idle after build");
		for (int i = 0; i < 7; i++) begin
			e = 16'(i < 5 ? 16'h1000 + i : 16'h2000 + i - 5);
			chk(seg_sink_i.words[i], e, "order");
		end
		$display("test_build done");
	endtask
	task test_layout;
		for (int v = 0; v < 4; v++) begin
			load(16'(v), 3, 1);
			if (v < 3) begin
				wait_ack(0, 1'b0);
				wait_ack(1, 1'b0);
			end else
				step(30);
			chk_ack("ack after check");
			chk({15'h0000, layout_err_q}, {15'h0000, v == 3}, "err");
			chk({15'h0000, dynamic_q}, {15'h0000, v == 2}, "dynamic");
		end
		$display("test_layout done");
	endtask
	task test_cmd;
		repeat (50) begin
			cmd_point = 2'b11;
			step();
		end
		cmd_point = 2'b00;
		cmd_end = 2'b11;
		step();
		cmd_end = 2'b00;
		for (int t = 0; t < 7; t++) begin
			step(4);
			chk_ack("early ack");
			chk({15'h0000, busy_q}, 16'h0001, "busy in finish");
			loop_tick = 1'b1;
			step();
			loop_tick = 1'b0;
		end
		step(2);
		exp_ack = ~exp_ack;
		chk_ack("both axes");
		repeat (3) begin
			cmd_point = 2'b01;
			step();
		end
		cmd_point = 2'b00;
		cmd_end = 2'b01;
		step();
		cmd_end = 2'b00;
		step();
		exp_ack[0] = ~exp_ack[0];
		chk_ack("short finish");
		$display("test_cmd done");
	endtask
	task test_fast;
		comm_calc = 1'b1;
		load(16'h0000, 20, 1);
		wait_ack(0, 1'b0);
		wait_ack(1, 1'b0);
		comm_calc = 1'b0;
		step(80);
		chk(16'(seg_sink_i.words.size()), 16'h0015, "drained");
		chk(seg_sink_i.words[19], 16'h1013, "last point");
		$display("test_fast done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		step(12);
		rst_n = 1'b1;
		step();
		test_regs();
		test_build();
		test_layout();
		test_cmd();
		test_fast();
		print_verdict();
	end
	// whole run needs a few hundred cycles
	initial begin
		#80000;
		mismatches++;
		print_verdict();
	end
endmodule
